// [bench/pscd_chk_chk.sv]
`include "pscd_defs.vh"
module pscd_chk (
   input wire logic        clk_sys,
   input wire logic        rstn,
   input wire logic        sl_reset,
   input wire logic        tx_valid,
   input wire logic        tx_ready,
   input wire logic        blk_ready,
   input wire logic        blk_valid,
   input wire logic        blk_flow,
   input wire logic [65:0] blk_data,
   input wire logic        rx_valid,
   input wire logic [65:0] rx_coded,
   input wire logic        rx_out_valid,
   input wire logic [7:0]  rxc,
   input wire logic [63:0] rxd
);
   timeunit 1ns;
   timeprecision 1ns;
   reg        seen_reg;
   reg        last_flow_reg;
   reg        prev_bad_reg;
   reg        prev_ok_reg;
   reg [65:0] rx_last_reg;
   // only bad sync is tracked as error history; other error kinds stay unchecked
   wire       cur_bad = (rx_coded[1:0] == 2'h0) || (rx_coded[1:0] == 2'h3);
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         seen_reg      <= 1'b0;
         last_flow_reg <= 1'b0;
         prev_bad_reg  <= 1'b0;
         prev_ok_reg   <= 1'b1;
         rx_last_reg   <= 66'h0;
      end else begin
         if (blk_valid && blk_ready) begin
            seen_reg      <= 1'b1;
            last_flow_reg <= blk_flow;
         end
         if (rx_valid) begin
            prev_bad_reg <= !sl_reset && cur_bad;
            prev_ok_reg  <= sl_reset || rx_coded[1:0] == 2'h2 ||
                            rx_coded == `PSCD_TX_IDLE_BLOCK;
            rx_last_reg  <= rx_coded;
         end
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   a_blk_hold: assert property (blk_valid && !blk_ready |=>
      blk_valid && $stable(blk_data) && $stable(blk_flow)) else $error("block moved while stalled");
   a_flow_alt: assert property (blk_valid |->
      blk_flow == (seen_reg ? !last_flow_reg : 1'b0)) else $error("flow not alternating");
   a_sync_legal: assert property (blk_valid |->
      blk_data[1:0] == 2'h1 || blk_data[1:0] == 2'h2) else $error("bad sync header");
   a_rx_pulse: assert property (rx_valid |=> rx_out_valid) else $error("no rx output");
   a_rx_quiet: assert property (!rx_valid |=>
      !rx_out_valid && $stable(rxd) && $stable(rxc)) else $error("rx output without word");
   a_rx_lf: assert property (rx_valid && sl_reset |=>
      {rxd, rxc} == `PSCD_RX_LF_VECTOR) else $error("no local fault vector");
   a_rx_err_cur: assert property (rx_valid && !sl_reset && cur_bad |=>
      {rxd, rxc} == `PSCD_RX_ERR_VECTOR) else $error("no error vector for bad block");
   a_rx_err_prev: assert property (rx_valid && !sl_reset && prev_bad_reg |=>
      {rxd, rxc} == `PSCD_RX_ERR_VECTOR) else $error("no error vector after bad block");
   a_rx_data: assert property (rx_valid && !sl_reset && prev_ok_reg &&
      rx_coded[1:0] == 2'h2 |=> rxc == 8'h00 && rxd == rx_last_reg[65:2])
      else $error("data block decoded wrongly");
   c_stall: cover property (blk_valid && !blk_ready);
   c_rx_bad: cover property (rx_valid && cur_bad);
   c_full: cover property (tx_valid && !tx_ready);
endmodule
bind pscd_codec pscd_chk u_chk (.clk_sys(clk_sys), .rstn(rstn), .sl_reset(sl_reset),
   .tx_valid(tx_valid), .tx_ready(tx_ready), .blk_ready(blk_ready), .blk_valid(blk_valid),
   .blk_flow(blk_flow), .blk_data(blk_data), .rx_valid(rx_valid), .rx_coded(rx_coded),
   .rx_out_valid(rx_out_valid), .rxc(rxc), .rxd(rxd));

// [bench/pscd_sink.sv]
module pscd_sink (
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   input  wire logic        stall,
   input  wire logic        blk_valid,
   input  wire logic        blk_flow,
   input  wire logic [65:0] blk_data,
   output logic             blk_ready
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [66:0] got_q[$];
   assign blk_ready = !stall;
   always @(posedge clk_sys)
      if (rstn && blk_valid && blk_ready) got_q.push_back({blk_flow, blk_data});
endmodule

// [bench/test_pscd_stateless_block_codec.sv]
`include "pscd_defs.vh"
module test_pscd_stateless_block_codec;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_sys, rstn, sl_reset, rm_en, tx_valid, tx_ready, blk_ready;
   logic        blk_valid, blk_flow, rx_valid, rx_out_valid, stall;
   logic [7:0]  txc, rxc;
   logic [63:0] txd, rxd;
   logic [65:0] blk_data, rx_coded;
   logic [65:0] exp_q[$];
   integer      err_count, num_checks, nblk, taken;
   localparam [63:0] IDL = `PSCD_IDLE_DATA;
   localparam [63:0] DA = 64'h0123456789ABCDEF;
   localparam [63:0] DB = 64'hF0E1D2C3B4A59687;
   localparam [65:0] IBLK = `PSCD_TX_IDLE_BLOCK;
   always #25 clk_sys = ~clk_sys;
   pscd_codec dut (.clk_sys(clk_sys), .rstn(rstn), .sl_reset(sl_reset), .rm_en(rm_en),
      .tx_valid(tx_valid), .txc(txc), .txd(txd), .tx_ready(tx_ready), .blk_ready(blk_ready),
      .blk_valid(blk_valid), .blk_flow(blk_flow), .blk_data(blk_data), .rx_valid(rx_valid),
      .rx_coded(rx_coded), .rx_out_valid(rx_out_valid), .rxc(rxc), .rxd(rxd));
   pscd_sink u_sink (.clk_sys(clk_sys), .rstn(rstn), .stall(stall), .blk_valid(blk_valid),
      .blk_flow(blk_flow), .blk_data(blk_data), .blk_ready(blk_ready));
   task check(input bit ok, input string msg);
      num_checks = num_checks + 1;
      if (!ok) begin
         err_count = err_count + 1;
         $display("ERROR at %0t: %s", $time, msg);
      end
   endtask
   task print_verdict;
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task timeout_hit;
      err_count = err_count + 1;
      $display("ERROR at %0t: wait bound used up", $time);
      print_verdict();
   endtask
   // holds valid high on return so back-to-back words need no idle edge
   task tx_put(input [7:0] c, input [63:0] d, input [65:0] e);
      integer n;
      begin
         txc <= c;
         txd <= d;
         tx_valid <= 1'b1;
         n = 0;
         @(posedge clk_sys);
         while (tx_ready !== 1'b1 && n < 40) begin
            @(posedge clk_sys);
            n = n + 1;
         end
         if (n >= 40) timeout_hit();
         exp_q.push_back(e);
      end
   endtask
   task drain;
      integer n;
      logic [66:0] g;
      begin
         tx_valid <= 1'b0;
         n = 0;
         while (u_sink.got_q.size() < exp_q.size() && n < 300) begin
            @(posedge clk_sys);
            n = n + 1;
         end
         if (n >= 300) timeout_hit();
         while (exp_q.size() > 0) begin
            g = u_sink.got_q.pop_front();
            check(g[65:0] === exp_q.pop_front(), "coded block mismatch");
            check(g[66] === nblk[0], "flow order wrong");
            nblk = nblk + 1;
         end
      end
   endtask
   task rx_put(input [65:0] w, input [71:0] e);
      rx_valid <= 1'b1;
      rx_coded <= w;
      @(posedge clk_sys);
      rx_valid <= 1'b0;
      rx_coded <= ~w;
      sl_reset <= 1'b0;
      #1;
      check(rx_out_valid === 1'b1, "no rx pulse");
      check({rxd, rxc} === e, "rx vector mismatch");
      @(posedge clk_sys);
   endtask
   task sc_reset;
      check(blk_data === `PSCD_TX_LF_BLOCK, "tx reset block");
      check({rxd, rxc} === `PSCD_RX_LF_VECTOR, "rx reset vector");
      check(blk_valid === 1'b0 && tx_ready === 1'b0, "busy in reset");
   endtask
   task sc_normal;
      tx_put(8'hFF, IDL, IBLK);
      tx_put(8'h01, {DA[63:8], 8'hFB}, {DA[63:8], 8'h78, 2'h1});
      tx_put(8'h00, DA, {DA, 2'h2});
      tx_put(8'h00, DB, {DB, 2'h2});
      tx_put(8'hFF, {IDL[63:8], 8'hFD}, {56'h0, 8'h87, 2'h1});
      tx_put(8'hFF, IDL, IBLK);
      drain();
   endtask
   task sc_illegal;
      tx_put(8'h00, DA, `PSCD_TX_ERR_BLOCK);
      tx_put(8'h01, {DB[63:8], 8'hFB}, `PSCD_TX_ERR_BLOCK);
      tx_put(8'hFF, IDL, `PSCD_TX_ERR_BLOCK);
      tx_put(8'hFF, IDL, IBLK);
      drain();
   endtask
   task sc_slreset;
      sl_reset <= 1'b1;
      tx_put(8'h00, DA, `PSCD_TX_LF_BLOCK);
      sl_reset <= 1'b0;
      tx_put(8'hFF, IDL, IBLK);
      drain();
   endtask
   task sc_fill;
      integer i;
      begin
         stall <= 1'b1;
         txc <= 8'hFF;
         txd <= IDL;
         tx_valid <= 1'b1;
         taken = 0;
         for (i = 0; i < 24; i = i + 1) begin
            @(posedge clk_sys);
            if (tx_ready === 1'b1) taken = taken + 1;
         end
         check(taken >= 5 && taken < 24, "buffer refusal wrong");
         stall <= 1'b0;
         for (i = 0; i < taken; i = i + 1) exp_q.push_back(IBLK);
         drain();
      end
   endtask
   task sc_rm;
      integer n;
      logic [66:0] g;
      begin
         rm_en <= 1'b1;
         n = 0;
         while (u_sink.got_q.size() == 0 && n < 40) begin
            @(posedge clk_sys);
            n = n + 1;
         end
         if (n >= 40) timeout_hit();
         rm_en <= 1'b0;
         repeat (10) @(posedge clk_sys);
         while (u_sink.got_q.size() > 0) begin
            g = u_sink.got_q.pop_front();
            check(g[65:0] === IBLK, "inserted block not idle");
            check(g[66] === nblk[0], "inserted flow wrong");
            nblk = nblk + 1;
         end
      end
   endtask
   task sc_rx;
      rx_put({DA, 2'h2}, {DA, 8'h00});
      rx_put({DB, 2'h0}, `PSCD_RX_ERR_VECTOR);
      rx_put({DB, 2'h2}, `PSCD_RX_ERR_VECTOR);
      rx_put({DB, 2'h2}, {DB, 8'h00});
      rx_put({56'h0, 8'h87, 2'h1}, {IDL[63:8], 8'hFD, 8'hFF});
      rx_put({DA, 2'h3}, `PSCD_RX_ERR_VECTOR);
      rx_put(IBLK, `PSCD_RX_ERR_VECTOR);
      rx_put(IBLK, {IDL, 8'hFF});
      sl_reset <= 1'b1;
      rx_put({DA, 2'h2}, `PSCD_RX_LF_VECTOR);
      rx_put({DB, 2'h2}, {DB, 8'h00});
   endtask
   initial begin
      clk_sys = 1'b0;
      rstn = 1'b0;
      sl_reset = 1'b0;
      rm_en = 1'b0;
      tx_valid = 1'b0;
      txc = 8'h00;
      txd = 64'h0;
      rx_valid = 1'b0;
      rx_coded = 66'h0;
      stall = 1'b0;
      err_count = 0;
      num_checks = 0;
      nblk = 0;
      repeat (8) @(posedge clk_sys);
      #1;
      sc_reset();
      repeat (8) @(posedge clk_sys);
      rstn <= 1'b1;
      repeat (2) @(posedge clk_sys);
      sc_normal();
      sc_illegal();
      sc_slreset();
      sc_fill();
      sc_rm();
      sc_rx();
      print_verdict();
   end
endmodule

// [include/pscd_defs.vh]
`ifndef PSCD_DEFS_VH
`define PSCD_DEFS_VH
`define PSCD_TY_C          3'h0
`define PSCD_TY_S          3'h1
`define PSCD_TY_D          3'h2
`define PSCD_TY_T          3'h3
`define PSCD_TY_E          3'h4
`define PSCD_SYNC_DATA     2'h2
`define PSCD_SYNC_CTRL     2'h1
`define PSCD_BT_CTRL       8'h1E
`define PSCD_BT_OSET       8'h4B
`define PSCD_BT_START      8'h78
`define PSCD_TERM_TYPES    64'hFFE1D2CCB4AA9987
`define PSCD_CH_IDLE       8'h07
`define PSCD_CH_ERR        8'hFE
`define PSCD_CH_START      8'hFB
`define PSCD_CH_TERM       8'hFD
`define PSCD_CH_SEQ        8'h9C
`define PSCD_CC_IDLE       7'h00
`define PSCD_CC_ERR        7'h1E
`define PSCD_IDLE_DATA     64'h0707070707070707
`define PSCD_TX_LF_BLOCK   {28'h0, 4'h0, 8'h01, 8'h00, 8'h00, 8'h4B, 2'h1}
`define PSCD_TX_ERR_BLOCK  {{8{7'h1E}}, 8'h1E, 2'h1}
`define PSCD_TX_IDLE_BLOCK {56'h0, 8'h1E, 2'h1}
`define PSCD_RX_LF_VECTOR  {64'h0100009C0100009C, 8'h11}
`define PSCD_RX_ERR_VECTOR {64'hFEFEFEFEFEFEFEFE, 8'hFF}
`define PSCD_TXRDY_LEVEL   4'h5
`define PSCD_RM_DEL_LEVEL  4'h4
`endif

// [src/pscd_codec.v]
`include "pscd_defs.vh"

module pscd_codec (
   input  wire        clk_sys,
   input  wire        rstn,
   input  wire        sl_reset,
   input  wire        rm_en,
   input  wire        tx_valid,
   input  wire [7:0]  txc,
   input  wire [63:0] txd,
   output wire        tx_ready,
   input  wire        blk_ready,
   output wire        blk_valid,
   output wire        blk_flow,
   output wire [65:0] blk_data,
   input  wire        rx_valid,
   input  wire [65:0] rx_coded,
   output wire        rx_out_valid,
   output wire [7:0]  rxc,
   output wire [63:0] rxd
);

   function ctl_ok;
      input [7:0] b;
      ctl_ok = (b == `PSCD_CH_IDLE) || (b == `PSCD_CH_ERR);
   endfunction

   function code_ok;
      input [6:0] c;
      code_ok = (c == `PSCD_CC_IDLE) || (c == `PSCD_CC_ERR);
   endfunction

   function [6:0] ctl_enc;
      input [7:0] b;
      ctl_enc = (b == `PSCD_CH_IDLE) ? `PSCD_CC_IDLE : `PSCD_CC_ERR;
   endfunction

   function [7:0] ctl_dec;
      input [6:0] c;
      ctl_dec = (c == `PSCD_CC_IDLE) ? `PSCD_CH_IDLE : `PSCD_CH_ERR;
   endfunction

   // block type of a terminate sitting in lane k
   function [7:0] term_type;
      input [2:0]  k;
      reg   [63:0] tt;
      begin
         tt        = `PSCD_TERM_TYPES;
         term_type = tt[8*k +: 8];
      end
   endfunction

   // classify a 72-bit transfer {data, control}
   function [2:0] tx_class;
      input [71:0] raw;
      reg   [7:0]  c;
      reg   [63:0] d;
      reg          ok;
      integer      j;
      integer      k;
      begin
         c = raw[7:0];
         d = raw[71:8];
         tx_class = `PSCD_TY_E;
         if (c == 8'h00) begin
            tx_class = `PSCD_TY_D;
         // an all-control word with terminate in lane 0 must reach the terminate search
         end else if (c == 8'hFF && d[7:0] != `PSCD_CH_TERM) begin
            ok = 1'b1;
            for (j = 0; j < 8; j = j + 1) begin
               ok = ok & ctl_ok(d[8*j +: 8]);
            end
            if (ok) tx_class = `PSCD_TY_C;
         end else if (c == 8'h01 && d[7:0] == `PSCD_CH_START) begin
            tx_class = `PSCD_TY_S;
         end else if (c == 8'hF1 && d[7:0] == `PSCD_CH_SEQ &&
                      ctl_ok(d[39:32]) && ctl_ok(d[47:40]) &&
                      ctl_ok(d[55:48]) && ctl_ok(d[63:56])) begin
            tx_class = `PSCD_TY_C;
         end else begin
            for (k = 0; k < 8; k = k + 1) begin
               if (c == (8'hFF << k) && d[8*k +: 8] == `PSCD_CH_TERM) begin
                  ok = 1'b1;
                  for (j = k + 1; j < 8; j = j + 1) begin
                     ok = ok & ctl_ok(d[8*j +: 8]);
                  end
                  if (ok) tx_class = `PSCD_TY_T;
               end
            end
         end
      end
   endfunction

   // normal 64b/66b encode; bit 0 of the result is sent first
   function [65:0] tx_encode;
      input [71:0] raw;
      input [2:0]  cls;
      reg   [7:0]  c;
      reg   [63:0] d;
      integer      j;
      integer      k;
      begin
         c = raw[7:0];
         d = raw[71:8];
         tx_encode = {64'h0, `PSCD_SYNC_CTRL};
         case (cls)
            `PSCD_TY_D: begin
               tx_encode = {d, `PSCD_SYNC_DATA};
            end
            `PSCD_TY_S: begin
               tx_encode = {d[63:8], `PSCD_BT_START, `PSCD_SYNC_CTRL};
            end
            `PSCD_TY_C: begin
               if (c == 8'hF1) begin
                  tx_encode[9:2] = `PSCD_BT_OSET;
                  tx_encode[33:10] = d[31:8];
                  for (j = 4; j < 8; j = j + 1) begin
                     tx_encode[10+7*j +: 7] = ctl_enc(d[8*j +: 8]);
                  end
               end else begin
                  tx_encode[9:2] = `PSCD_BT_CTRL;
                  for (j = 0; j < 8; j = j + 1) begin
                     tx_encode[10+7*j +: 7] = ctl_enc(d[8*j +: 8]);
                  end
               end
            end
            `PSCD_TY_T: begin
               for (k = 0; k < 8; k = k + 1) begin
                  if (c == (8'hFF << k)) begin
                     tx_encode[9:2] = term_type(k[2:0]);
                     for (j = 0; j < 8; j = j + 1) begin
                        if (j < k) tx_encode[10+8*j +: 8] = d[8*j +: 8];
                        if (j > k) tx_encode[10+7*j +: 7] = ctl_enc(d[8*j +: 8]);
                     end
                  end
               end
            end
            default: begin
               tx_encode = `PSCD_TX_ERR_BLOCK;
            end
         endcase
      end
   endfunction

   // classify a received 66-bit block
   function [2:0] rx_class;
      input [65:0] blk;
      reg   [7:0]  ty;
      reg          ok;
      integer      j;
      integer      k;
      begin
         ty = blk[9:2];
         rx_class = `PSCD_TY_E;
         if (blk[1:0] == `PSCD_SYNC_DATA) begin
            rx_class = `PSCD_TY_D;
         end else if (blk[1:0] == `PSCD_SYNC_CTRL) begin
            if (ty == `PSCD_BT_START) begin
               rx_class = `PSCD_TY_S;
            end else if (ty == `PSCD_BT_CTRL || ty == `PSCD_BT_OSET) begin
               ok = (ty == `PSCD_BT_CTRL) || (blk[37:34] == 4'h0);
               for (j = 0; j < 8; j = j + 1) begin
                  if (ty == `PSCD_BT_CTRL || j > 3) ok = ok & code_ok(blk[10+7*j +: 7]);
               end
               if (ok) rx_class = `PSCD_TY_C;
            end else begin
               for (k = 0; k < 8; k = k + 1) begin
                  if (ty == term_type(k[2:0])) begin
                     ok = 1'b1;
                     for (j = k + 1; j < 8; j = j + 1) begin
                        ok = ok & code_ok(blk[10+7*j +: 7]);
                     end
                     if (ok) rx_class = `PSCD_TY_T;
                  end
               end
            end
         end
      end
   endfunction

   // normal decode into {data, control}
   function [71:0] rx_decode;
      input [65:0] blk;
      input [2:0]  cls;
      reg   [7:0]  c;
      reg   [63:0] d;
      integer      j;
      integer      k;
      begin
         c = 8'h00;
         d = 64'h0;
         case (cls)
            `PSCD_TY_D: begin
               d = blk[65:2];
            end
            `PSCD_TY_S: begin
               c = 8'h01;
               d = {blk[65:10], `PSCD_CH_START};
            end
            `PSCD_TY_C: begin
               c = 8'hFF;
               for (j = 0; j < 8; j = j + 1) begin
                  d[8*j +: 8] = ctl_dec(blk[10+7*j +: 7]);
               end
               if (blk[9:2] == `PSCD_BT_OSET) begin
                  c = 8'hF1;
                  d[31:0] = {blk[33:10], `PSCD_CH_SEQ};
               end
            end
            `PSCD_TY_T: begin
               for (k = 0; k < 8; k = k + 1) begin
                  if (blk[9:2] == term_type(k[2:0])) begin
                     c = 8'hFF << k;
                     for (j = 0; j < 8; j = j + 1) begin
                        if (j < k) d[8*j +: 8] = blk[10+8*j +: 8];
                        if (j == k) d[8*j +: 8] = `PSCD_CH_TERM;
                        if (j > k) d[8*j +: 8] = ctl_dec(blk[10+7*j +: 7]);
                     end
                  end
               end
            end
            default: begin
               {d, c} = `PSCD_RX_ERR_VECTOR;
            end
         endcase
         rx_decode = {d, c};
      end
   endfunction

   reg  [2:0]  tx_prev_reg;
   reg         enc_valid_reg;
   reg  [65:0] enc_blk_reg;
   reg         tx_ready_reg;
   reg         blk_valid_reg;
   reg         blk_flow_reg;
   reg  [65:0] blk_data_reg;
   reg         flow_sel_reg;
   reg  [2:0]  rx_prev_reg;
   reg         rx_out_valid_reg;
   reg  [71:0] rx_raw_reg;
   reg  [65:0] enc_next;
   reg  [71:0] rx_next;

   wire [71:0] tx_raw;
   wire [2:0]  tx_cls;
   wire        tx_take;
   wire        tx_idle;
   wire        rm_drop;
   wire        fifo_in_ready;
   wire        fifo_out_valid;
   wire [65:0] fifo_out_data;
   wire [3:0]  fifo_level;
   wire        out_free;
   wire        pop;
   wire [2:0]  last_cls;
   wire [2:0]  rx_cls;

   assign tx_raw  = {txd, txc};
   assign tx_cls  = tx_class(tx_raw);
   assign tx_take = tx_valid & tx_ready_reg;
   assign tx_idle = (txc == 8'hFF) && (txd == `PSCD_IDLE_DATA);
   // only pure idle is dropped, so the type history stays C-to-C legal
   assign rm_drop = rm_en & tx_idle & ~sl_reset &
                    (fifo_level >= `PSCD_RM_DEL_LEVEL);

   // stateless encoder: one block per transfer from current and previous type
   always @* begin
      enc_next = `PSCD_TX_ERR_BLOCK;
      if (sl_reset) begin
         enc_next = `PSCD_TX_LF_BLOCK;
      end else if ((tx_prev_reg == `PSCD_TY_C || tx_prev_reg == `PSCD_TY_T) &&
                   (tx_cls == `PSCD_TY_C || tx_cls == `PSCD_TY_S)) begin
         enc_next = tx_encode(tx_raw, tx_cls);
      end else if ((tx_prev_reg == `PSCD_TY_S || tx_prev_reg == `PSCD_TY_D) &&
                   (tx_cls == `PSCD_TY_D || tx_cls == `PSCD_TY_T)) begin
         enc_next = tx_encode(tx_raw, tx_cls);
      end
   end

   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         tx_prev_reg   <= `PSCD_TY_C;
         enc_valid_reg <= 1'b0;
         enc_blk_reg   <= `PSCD_TX_LF_BLOCK;
         tx_ready_reg  <= 1'b0;
      end else begin
         // ready looks one cycle back, so leave room for words in flight
         tx_ready_reg  <= (fifo_level < `PSCD_TXRDY_LEVEL);
         enc_valid_reg <= tx_take & ~rm_drop;
         if (tx_take) begin
            enc_blk_reg <= enc_next;
            tx_prev_reg <= sl_reset ? `PSCD_TY_C : tx_cls;
         end
      end
   end

   pscd_fifo #(
      .WIDTH (66),
      .DEPTH (8),
      .AW    (3)
   ) u_fifo (
      .clk_sys   (clk_sys),
      .rstn      (rstn),
      .in_valid  (enc_valid_reg),
      .in_ready  (fifo_in_ready),
      .in_data   (enc_blk_reg),
      .out_valid (fifo_out_valid),
      .out_ready (out_free),
      .out_data  (fifo_out_data),
      .level     (fifo_level)
   );

   assign out_free = ~blk_valid_reg | blk_ready;
   assign pop      = fifo_out_valid & out_free;
   assign last_cls = rx_class(blk_data_reg);

   // distribution: alternate flows; idle fill only between packets
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         blk_valid_reg <= 1'b0;
         blk_flow_reg  <= 1'b0;
         blk_data_reg  <= `PSCD_TX_LF_BLOCK;
         flow_sel_reg  <= 1'b0;
      end else if (out_free) begin
         if (pop) begin
            blk_valid_reg <= 1'b1;
            blk_data_reg  <= fifo_out_data;
            blk_flow_reg  <= flow_sel_reg;
            flow_sel_reg  <= ~flow_sel_reg;
         end else if (rm_en && !sl_reset &&
                      (last_cls == `PSCD_TY_C || last_cls == `PSCD_TY_T)) begin
            blk_valid_reg <= 1'b1;
            blk_data_reg  <= `PSCD_TX_IDLE_BLOCK;
            blk_flow_reg  <= flow_sel_reg;
            flow_sel_reg  <= ~flow_sel_reg;
         end else begin
            blk_valid_reg <= 1'b0;
         end
      end
   end

   assign rx_cls = rx_class(rx_coded);

   // stateless decoder: current block and previous block type only
   always @* begin
      rx_next = rx_decode(rx_coded, rx_cls);
      if (sl_reset) begin
         rx_next = `PSCD_RX_LF_VECTOR;
      end else if (rx_cls == `PSCD_TY_E) begin
         rx_next = `PSCD_RX_ERR_VECTOR;
      end else if (rx_prev_reg == `PSCD_TY_E) begin
         rx_next = `PSCD_RX_ERR_VECTOR;
      end
   end

   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rx_prev_reg      <= `PSCD_TY_C;
         rx_out_valid_reg <= 1'b0;
         rx_raw_reg       <= `PSCD_RX_LF_VECTOR;
      end else begin
         rx_out_valid_reg <= rx_valid;
         if (rx_valid) begin
            rx_raw_reg  <= rx_next;
            rx_prev_reg <= sl_reset ? `PSCD_TY_C : rx_cls;
         end
      end
   end

   assign tx_ready     = tx_ready_reg;
   assign blk_valid    = blk_valid_reg;
   assign blk_flow     = blk_flow_reg;
   assign blk_data     = blk_data_reg;
   assign rx_out_valid = rx_out_valid_reg;
   assign rxc          = rx_raw_reg[7:0];
   assign rxd          = rx_raw_reg[71:8];

endmodule

// [src/pscd_fifo.v]
module pscd_fifo #(
   parameter WIDTH = 66,
   parameter DEPTH = 8,
   parameter AW    = 3
) (
   input  wire             clk_sys,
   input  wire             rstn,
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data,
   output wire [AW:0]      level
);
   localparam [AW:0] FULL_LVL = DEPTH[AW:0];

   reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
   reg [AW-1:0]    wr_ptr_reg;
   reg [AW-1:0]    rd_ptr_reg;
   reg [AW:0]      level_reg;
   wire            push;
   wire            pop;
   integer         i;

   assign in_ready  = (level_reg != FULL_LVL);
   assign out_valid = (level_reg != {(AW+1){1'b0}});
   assign out_data  = mem_reg[rd_ptr_reg];
   assign level     = level_reg;
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         wr_ptr_reg <= {AW{1'b0}};
         rd_ptr_reg <= {AW{1'b0}};
         level_reg  <= {(AW+1){1'b0}};
         for (i = 0; i < DEPTH; i = i + 1) begin
            mem_reg[i] <= {WIDTH{1'b0}};
         end
      end else begin
         if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
            wr_ptr_reg          <= wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
         if (push && !pop) begin
            level_reg <= level_reg + 1'b1;
         end else if (pop && !push) begin
            level_reg <= level_reg - 1'b1;
         end
      end
   end
endmodule
